// file: rtl/e1m_mapper.sv
// e1 unprotected frame mapper: payload handshake, g.704 serializer and alignment receiver
`timescale 1ns/1ns
module e1m_mapper #(
    parameter int PHASE = 4
) (
    input wire logic clk_i,
    input wire logic rstn_i,
    input wire logic link_clk_i,
    input wire logic [7:0] pay_data_i,
    input wire logic pay_valid_i,
    output logic pay_ready_o,
    output logic pay_first_o,
    output logic [12:0] transport_frame_length_o,
    output logic underrun_o,
    output logic aligned_o,
    output logic align_lost_o,
    output logic tx_bit_o,
    output logic tx_frame_o,
    input wire logic rx_bit_i,
    output logic [7:0] rx_data_o,
    output logic rx_valid_o,
    output logic [4:0] rx_slot_o,
    output logic rx_sync_o
);
    import e1m_pkg::*;

    localparam logic [4:0] PH5 = 5'(PHASE);

    // ---------------- system clock side ----------------
    logic [7:0] hold_data;
    logic req_tgl;
    logic busy;
    logic [12:0] acc_cnt;
    logic [12:0] next_acc;
    logic urun_d;
    logic lost_d;
    logic [3:0] s_sync;
    logic ack_s;
    logic take;
    // link side signals read across the crossing
    logic ack_tgl;
    logic urun_tgl;
    logic lof_tgl;

    e1m_sync #(.W(4)) u_sys_sync (
        .clk_i(clk_i),
        .rstn_i(rstn_i),
        .d_i({ack_tgl, urun_tgl, rx_sync_o, lof_tgl}),
        .q_o(s_sync)
    );

    assign ack_s = s_sync[3];
    assign take = pay_valid_i && pay_ready_o;
    assign next_acc = take ? ((acc_cnt == TF_LEN_LAST) ? 13'h0000 : acc_cnt + 13'h0001) : acc_cnt;

    // hold register stays stable while the link side copies it
    always_ff @(posedge clk_i or negedge rstn_i) begin
        if (!rstn_i) begin
            hold_data <= 8'h00;
            req_tgl <= 1'b0;
        end else if (take) begin
            hold_data <= pay_data_i;
            req_tgl <= ~req_tgl;
        end
    end

    always_ff @(posedge clk_i or negedge rstn_i) begin
        if (!rstn_i) begin
            busy <= 1'b0;
            pay_ready_o <= 1'b0;
        end else begin
            busy <= take || (busy && (ack_s != req_tgl));
            pay_ready_o <= !(take || (busy && (ack_s != req_tgl)));
        end
    end

    // position of the next byte inside the transport frame
    always_ff @(posedge clk_i or negedge rstn_i) begin
        if (!rstn_i) begin
            acc_cnt <= 13'h0000;
            pay_first_o <= 1'b0;
            transport_frame_length_o <= 13'h0000;
        end else begin
            acc_cnt <= next_acc;
            pay_first_o <= (next_acc == 13'h0000);
            transport_frame_length_o <= TF_LEN_VAL;
        end
    end

    always_ff @(posedge clk_i or negedge rstn_i) begin
        if (!rstn_i) begin
            urun_d <= 1'b0;
            lost_d <= 1'b0;
            underrun_o <= 1'b0;
            align_lost_o <= 1'b0;
            aligned_o <= 1'b0;
        end else begin
            urun_d <= s_sync[2];
            lost_d <= s_sync[0];
            underrun_o <= s_sync[2] ^ urun_d;
            align_lost_o <= s_sync[0] ^ lost_d;
            aligned_o <= s_sync[1];
        end
    end

    // ---------------- link clock side ----------------
    logic lrstn;
    logic [1:0] l_sync;
    logic req_s;
    logic rx_s;
    logic [7:0] lpay;
    logic lpay_vld;
    logic run;
    logic [2:0] bit_idx;
    logic [12:0] q;
    logic [7:0] sh;
    logic fas_par;
    logic frm_d;
    logic ld;
    logic [12:0] q_nxt;
    logic [4:0] slot_nxt;
    logic is_pay;
    logic consume;
    logic go;
    logic [7:0] ld_byte;

    e1m_sync #(.W(1)) u_link_rst (
        .clk_i(link_clk_i),
        .rstn_i(rstn_i),
        .d_i(1'b1),
        .q_o(lrstn)
    );

    e1m_sync #(.W(2)) u_link_sync (
        .clk_i(link_clk_i),
        .rstn_i(lrstn),
        .d_i({req_tgl, rx_bit_i}),
        .q_o(l_sync)
    );

    assign req_s = l_sync[1];
    assign rx_s = l_sync[0];
    assign ld = (bit_idx == 3'h7);
    assign q_nxt = (q == Q_LAST) ? 13'h0000 : q + 13'h0001;
    assign slot_nxt = q_nxt[4:0] + PH5;
    assign is_pay = (slot_nxt != SLOT_ZERO) && (slot_nxt != SLOT_SIXTEEN);
    // payload may start in the very slot that opens the frame
    assign go = run || ((q == Q_LAST) && lpay_vld);
    assign consume = ld && is_pay && go && lpay_vld;

    // byte chosen for the next output index
    always_comb begin
        if (slot_nxt == SLOT_ZERO) begin
            ld_byte = fas_par ? NFAS_BYTE : FAS_BYTE;
        end else if (slot_nxt == SLOT_SIXTEEN) begin
            ld_byte = SUP_BYTE;
        end else if (go && lpay_vld) begin
            ld_byte = lpay;
        end else begin
            ld_byte = FILL_BYTE;
        end
    end

    // copy one byte across once the request toggle has settled
    always_ff @(posedge link_clk_i or negedge lrstn) begin
        if (!lrstn) begin
            lpay <= 8'h00;
            lpay_vld <= 1'b0;
            ack_tgl <= 1'b0;
        end else if ((req_s != ack_tgl) && !lpay_vld) begin
            lpay <= hold_data;
            lpay_vld <= 1'b1;
            ack_tgl <= ~ack_tgl;
        end else if (consume) begin
            lpay_vld <= 1'b0;
        end
    end

    // payload starts at a frame boundary once the first byte is present
    always_ff @(posedge link_clk_i or negedge lrstn) begin
        if (!lrstn) begin
            run <= 1'b0;
            urun_tgl <= 1'b0;
        end else begin
            if (ld && (q == Q_LAST) && lpay_vld) begin
                run <= 1'b1;
            end
            if (ld && is_pay && run && !lpay_vld) begin
                urun_tgl <= ~urun_tgl;
            end
        end
    end

    // serializer, first cycle after reset loads index 0
    always_ff @(posedge link_clk_i or negedge lrstn) begin
        if (!lrstn) begin
            bit_idx <= 3'h7;
            q <= Q_LAST;
            sh <= FILL_BYTE;
            fas_par <= 1'b0;
        end else if (ld) begin
            bit_idx <= 3'h0;
            q <= q_nxt;
            sh <= ld_byte;
            if (slot_nxt == SLOT_ZERO) begin
                fas_par <= ~fas_par;
            end
        end else begin
            bit_idx <= bit_idx + 3'h1;
            sh <= {1'b1, sh[7:1]};
        end
    end

    always_ff @(posedge link_clk_i or negedge lrstn) begin
        if (!lrstn) begin
            tx_bit_o <= 1'b1;
            frm_d <= 1'b0;
            tx_frame_o <= 1'b0;
        end else begin
            tx_bit_o <= sh[0];
            frm_d <= ld && (q_nxt == 13'h0000);
            tx_frame_o <= frm_d;
        end
    end

    // ---------------- alignment receiver ----------------
    e1m_rx_state_t state;
    logic [7:0] rsh;
    logic [8:0] rcnt;
    logic [1:0] miss;
    logic fas_hit;
    logic nfas_ok;

    assign fas_hit = (rsh[7:1] == FAS_MASKED);
    assign nfas_ok = !fas_hit && rsh[0];

    always_ff @(posedge link_clk_i or negedge lrstn) begin
        if (!lrstn) begin
            rsh <= 8'h00;
            rcnt <= 9'h000;
        end else begin
            rsh <= {rx_s, rsh[7:1]};
            rcnt <= ((state == E1M_HUNT) && fas_hit) ? 9'h000 : rcnt + 9'h001;
        end
    end

    always_ff @(posedge link_clk_i or negedge lrstn) begin
        if (!lrstn) begin
            state <= E1M_HUNT;
            miss <= 2'h0;
            lof_tgl <= 1'b0;
        end else begin
            case (state)
                E1M_HUNT: begin
                    miss <= 2'h0;
                    if (fas_hit) begin
                        state <= E1M_CHK1;
                    end
                end
                E1M_CHK1: begin
                    if (rcnt == BIT_HALF) begin
                        state <= nfas_ok ? E1M_CHK2 : E1M_HUNT;
                    end
                end
                E1M_CHK2: begin
                    if (rcnt == BIT_FULL) begin
                        state <= fas_hit ? E1M_SYNC : E1M_HUNT;
                    end
                end
                E1M_SYNC: begin
                    if (rcnt == BIT_FULL) begin
                        if (fas_hit) begin
                            miss <= 2'h0;
                        end else if (miss == MISS_LIMIT) begin
                            state <= E1M_HUNT;
                            lof_tgl <= ~lof_tgl;
                        end else begin
                            miss <= miss + 2'h1;
                        end
                    end
                end
                default: begin
                    state <= E1M_HUNT;
                end
            endcase
        end
    end

    always_ff @(posedge link_clk_i or negedge lrstn) begin
        if (!lrstn) begin
            rx_data_o <= 8'h00;
            rx_valid_o <= 1'b0;
            rx_slot_o <= 5'h00;
            rx_sync_o <= 1'b0;
        end else begin
            rx_data_o <= rsh;
            rx_valid_o <= (state == E1M_SYNC) && (rcnt[2:0] == 3'h7);
            rx_slot_o <= rcnt[7:3] + 5'h01;
            rx_sync_o <= (state == E1M_SYNC);
        end
    end

    // ---------------- checks ----------------
    logic [12:0] pcnt;
    logic first_done;
    logic [7:0] last_sb;

    always_ff @(posedge link_clk_i or negedge lrstn) begin
        if (!lrstn) begin
            pcnt <= 13'h0000;
            first_done <= 1'b0;
            last_sb <= 8'h00;
        end else if (ld) begin
            if (q_nxt == 13'h0000) begin
                pcnt <= {12'h000, is_pay};
                first_done <= 1'b1;
            end else begin
                pcnt <= pcnt + {12'h000, is_pay};
            end
            if (slot_nxt == SLOT_ZERO) begin
                last_sb <= ld_byte;
            end
        end
    end

    property p_frame_wrap;
        @(posedge link_clk_i) disable iff (!lrstn)
        ld && (q == Q_LAST) |=> (q == 13'h0000) ##1 (q == 13'h0000) [*7];
    endproperty
    a_frame_wrap: assert property (p_frame_wrap) else $error("frame did not wrap after index 6143");

    property p_seq;
        @(posedge link_clk_i) disable iff (!lrstn)
        ld && (q != Q_LAST) |=> (q == $past(q) + 13'h0001);
    endproperty
    a_seq: assert property (p_seq) else $error("output index skipped");

    property p_pay_count;
        @(posedge link_clk_i) disable iff (!lrstn)
        ld && (q_nxt == 13'h0000) && first_done |-> (pcnt == TF_LEN_VAL);
    endproperty
    a_pay_count: assert property (p_pay_count) else $error("payload slots per frame not 5760");

    property p_ts0;
        @(posedge link_clk_i) disable iff (!lrstn)
        ld && (slot_nxt == SLOT_ZERO) |=> ((sh == FAS_BYTE) || (sh == NFAS_BYTE)) && !$past(consume);
    endproperty
    a_ts0: assert property (p_ts0) else $error("slot zero carried payload");

    property p_slot_sixteen;
        @(posedge link_clk_i) disable iff (!lrstn)
        ld && (slot_nxt == SLOT_SIXTEEN) |=> (sh == SUP_BYTE) && !$past(consume);
    endproperty
    a_slot_sixteen: assert property (p_slot_sixteen) else $error("slot sixteen carried payload");

    property p_pass;
        @(posedge link_clk_i) disable iff (!lrstn)
        consume |=> (sh == $past(lpay)) && !lpay_vld;
    endproperty
    a_pass: assert property (p_pass) else $error("payload byte altered");

    property p_lsb;
        @(posedge link_clk_i) disable iff (!lrstn)
        ld |-> ##2 (tx_bit_o == $past(ld_byte[0], 2)) ##7 (tx_bit_o == $past(ld_byte[7], 9));
    endproperty
    a_lsb: assert property (p_lsb) else $error("serial bit order wrong");

    property p_alt;
        @(posedge link_clk_i) disable iff (!lrstn)
        ld && (slot_nxt == SLOT_ZERO) && first_done |-> (ld_byte != last_sb);
    endproperty
    a_alt: assert property (p_alt) else $error("sync bytes did not alternate");

    property p_acq;
        @(posedge link_clk_i) disable iff (!lrstn)
        (state == E1M_CHK2) && (rcnt == BIT_FULL) && fas_hit |=> (state == E1M_SYNC) ##1 rx_sync_o;
    endproperty
    a_acq: assert property (p_acq) else $error("alignment not declared");

    property p_lof;
        @(posedge link_clk_i) disable iff (!lrstn)
        (state == E1M_SYNC) && (rcnt == BIT_FULL) && !fas_hit && (miss == MISS_LIMIT)
            |=> (state == E1M_HUNT) && (lof_tgl != $past(lof_tgl));
    endproperty
    a_lof: assert property (p_lof) else $error("alignment not lost after three misses");

    property p_tf_len;
        @(posedge clk_i) disable iff (!rstn_i)
        pay_ready_o |-> (transport_frame_length_o == TF_LEN_VAL);
    endproperty
    a_tf_len: assert property (p_tf_len) else $error("transport frame length not 5760");

    c_sync: cover property (@(posedge link_clk_i) disable iff (!lrstn) $rose(rx_sync_o));
    c_lof: cover property (@(posedge link_clk_i) disable iff (!lrstn) $changed(lof_tgl));
    c_wrap: cover property (@(posedge link_clk_i) disable iff (!lrstn) run && tx_frame_o);
    c_urun: cover property (@(posedge clk_i) disable iff (!rstn_i) underrun_o);
endmodule : e1m_mapper

// file: rtl/e1m_pkg.sv
// shared constants and types for the e1 unprotected frame mapper
package e1m_pkg;
    // adaptation frame timing
    localparam int FRAME_MS = 24;
    localparam int LINE_KBPS = 2048;
    localparam int FRAME_BYTES = FRAME_MS * LINE_KBPS / 8;
    localparam int TF_LEN_BYTES = 5760;
    localparam logic [12:0] Q_LAST = 13'(FRAME_BYTES - 1);
    localparam logic [12:0] TF_LEN_VAL = 13'(TF_LEN_BYTES);
    localparam logic [12:0] TF_LEN_LAST = 13'(TF_LEN_BYTES - 1);
    // slot positions inside a 32-byte g.704 frame
    localparam logic [4:0] SLOT_ZERO = 5'h00;
    localparam logic [4:0] SLOT_SIXTEEN = 5'h10;
    // byte contents, bit 0 is sent first
    localparam logic [6:0] FAS_MASKED = 7'h6C;
    localparam logic [7:0] FAS_BYTE = {FAS_MASKED, 1'b1};
    localparam logic [7:0] NFAS_BYTE = 8'hFF;
    localparam logic [7:0] SUP_BYTE = 8'hFF;
    localparam logic [7:0] FILL_BYTE = 8'hFF;
    // receive alignment timing in line bits
    localparam logic [8:0] BIT_HALF = 9'h0FF;
    localparam logic [8:0] BIT_FULL = 9'h1FF;
    localparam logic [1:0] MISS_LIMIT = 2'h2;

    typedef enum logic [1:0] {
        E1M_HUNT = 2'b00,
        E1M_CHK1 = 2'b01,
        E1M_CHK2 = 2'b11,
        E1M_SYNC = 2'b10
    } e1m_rx_state_t;
endpackage : e1m_pkg

// file: rtl/e1m_sync.sv
// two flip-flop synchroniser for W independent levels
`timescale 1ns/1ns
module e1m_sync #(
    parameter int W = 1
) (
    input wire logic clk_i,
    input wire logic rstn_i,
    input wire logic [W-1:0] d_i,
    output logic [W-1:0] q_o
);
    logic [W-1:0] meta;

    always_ff @(posedge clk_i or negedge rstn_i) begin
        if (!rstn_i) begin
            meta <= '0;
            q_o <= '0;
        end else begin
            meta <= d_i;
            q_o <= meta;
        end
    end
endmodule : e1m_sync

// file: testbench/e1m_peer.sv
// far-end model: line byte capture and loopback with optional inversion
`timescale 1ns/1ns
module e1m_peer (
    input wire logic link_clk_i,
    input wire logic tx_bit_i,
    input wire logic tx_frame_i,
    input wire logic corrupt_i,
    output logic rx_bit_o,
    output logic [7:0] byte_o,
    output logic [12:0] idx_o,
    output logic stb_o
);
    logic [2:0] bitc = 3'h0;
    logic [12:0] nidx = 13'h0000;
    logic [7:0] sh = 8'h00;

    initial stb_o = 1'b0;
    // inversion breaks every sync byte seen by the receiver
    assign rx_bit_o = tx_bit_i ^ corrupt_i;

    always @(posedge link_clk_i) begin
        stb_o <= 1'b0;
        sh <= {tx_bit_i, sh[7:1]};
        bitc <= tx_frame_i ? 3'h1 : bitc + 3'h1;
        nidx <= tx_frame_i ? 13'h0000 : nidx;
        if (!tx_frame_i && bitc == 3'h7) begin
            byte_o <= {tx_bit_i, sh[7:1]};
            idx_o <= nidx;
            nidx <= nidx + 13'h0001;
            stb_o <= 1'b1;
        end
    end
endmodule : e1m_peer

// file: testbench/testbench.sv
// self-checking bench for the e1 unprotected frame mapper
`timescale 1ns/1ns
module testbench;
    import e1m_pkg::*;
    localparam int PH = 7;
    logic clk_i = 1'b0;
    logic link_clk_i = 1'b0;
    logic rstn_i;
    logic [7:0] pay_data_i = 8'h00;
    logic pay_valid_i = 1'b0;
    logic corrupt = 1'b0;
    logic pay_ready_o, pay_first_o, underrun_o, aligned_o, align_lost_o;
    logic tx_bit_o, tx_frame_o, rx_bit, rx_valid_o, rx_sync_o, stb;
    logic [12:0] tf_len, pidx;
    logic [7:0] rx_data_o, pbyte;
    logic [4:0] rx_slot_o;
    int miscompares = 0;
    int n_compared = 0;
    int n_under = 0;
    int cyc = 0;
    int lcnt = 0;
    int period = 0;

    initial forever #2 clk_i = ~clk_i;
    initial begin
        #1;
        forever #6 link_clk_i = ~link_clk_i;
    end

    e1m_mapper #(.PHASE(PH)) i_e1m_mapper (.clk_i(clk_i), .rstn_i(rstn_i), .link_clk_i(link_clk_i),
        .pay_data_i(pay_data_i), .pay_valid_i(pay_valid_i), .pay_ready_o(pay_ready_o),
        .pay_first_o(pay_first_o), .transport_frame_length_o(tf_len), .underrun_o(underrun_o),
        .aligned_o(aligned_o), .align_lost_o(align_lost_o), .tx_bit_o(tx_bit_o), .tx_frame_o(tx_frame_o),
        .rx_bit_i(rx_bit), .rx_data_o(rx_data_o), .rx_valid_o(rx_valid_o), .rx_slot_o(rx_slot_o),
        .rx_sync_o(rx_sync_o));

    e1m_peer i_e1m_peer (.link_clk_i(link_clk_i), .tx_bit_i(tx_bit_o), .tx_frame_i(tx_frame_o),
        .corrupt_i(corrupt), .rx_bit_o(rx_bit), .byte_o(pbyte), .idx_o(pidx), .stb_o(stb));

    function automatic logic [7:0] pat(int k);
        return 8'(k * 13 + 5);
    endfunction : pat

    task automatic check(logic ok, string msg);
        n_compared++;
        if (ok !== 1'b1) begin
            miscompares++;
            $display("BAD %0t %s", $time, msg);
        end
    endtask : check

    task automatic close_out();
        if (miscompares == 0 && n_compared > 0) $display("All tests passed");
        else $display("Some tests failed");
        $finish;
    endtask : close_out

    always @(posedge clk_i) begin
        cyc <= cyc + 1;
        if (underrun_o === 1'b1) n_under <= n_under + 1;
        if (cyc == 260000) begin
            miscompares++;
            $display("BAD %0t run hung", $time);
            close_out();
        end
    end

    always @(posedge link_clk_i) begin
        if (tx_frame_o === 1'b1) begin
            period <= lcnt;
            lcnt <= 1;
        end else begin
            lcnt <= lcnt + 1;
        end
    end

    task automatic next_byte(output logic [7:0] b, output logic [12:0] q);
        do @(negedge link_clk_i); while (stb !== 1'b1);
        b = pbyte;
        q = pidx;
    endtask : next_byte

    // one byte per handshake, valid dropped for a cycle after each take
    task automatic produce();
        int k = 0;
        @(posedge clk_i);
        forever begin
            pay_data_i <= pat(k);
            pay_valid_i <= 1'b1;
            do @(negedge clk_i); while (pay_ready_o !== 1'b1);
            if (k < 2) check(pay_first_o === 1'(k == 0), "first byte flag");
            @(posedge clk_i);
            pay_valid_i <= 1'b0;
            @(posedge clk_i);
            k++;
        end
    endtask : produce

    task automatic t_reset();
        @(posedge clk_i);
        @(negedge clk_i);
        check(tf_len === 13'h1680, "length field");
        check(pay_first_o === 1'b1, "first flag after reset");
    endtask : t_reset

    // first frame carries fill only: slot layout from the phase
    task automatic t_frame0();
        logic [7:0] b;
        logic [4:0] s;
        logic [12:0] q;
        int n0 = 0;
        do @(negedge link_clk_i); while (tx_frame_o !== 1'b1);
        fork
            produce();
        join_none
        for (int i = 0; i < 6144; i++) begin
            next_byte(b, q);
            s = 5'(i + PH);
            check(q === 13'(i), "byte order");
            if (s == SLOT_ZERO) begin
                check(b === ((n0 % 2 == 0) ? FAS_BYTE : NFAS_BYTE), "sync byte");
                n0++;
            end else if (s == SLOT_SIXTEEN) begin
                check(b === SUP_BYTE, "supervision byte");
            end else begin
                check(b === FILL_BYTE, "idle payload slot");
            end
        end
    endtask : t_frame0

    task automatic t_payload();
        logic [7:0] b;
        logic [4:0] s;
        logic [12:0] q;
        int k = 0;
        // frame 1 follows frame 0 at once: its first byte is the next strobe
        for (int i = 0; i < 400; i++) begin
            next_byte(b, q);
            check(q === 13'(i), "payload frame order");
            s = 5'(i + PH);
            if (s != SLOT_ZERO && s != SLOT_SIXTEEN) begin
                check(b === pat(k), "payload byte");
                k++;
            end
        end
        check(n_under == 0, "payload slot starved");
        check(period == 49152, "frame period");
    endtask : t_payload

    task automatic t_align();
        logic [7:0] b0, b1;
        int n = 0;
        check(aligned_o === 1'b1, "aligned on loopback");
        do @(negedge link_clk_i); while (!(rx_valid_o === 1'b1 && rx_slot_o === SLOT_SIXTEEN));
        check(rx_data_o === SUP_BYTE, "received supervision");
        do @(negedge link_clk_i); while (!(rx_valid_o === 1'b1 && rx_slot_o === SLOT_ZERO));
        b0 = rx_data_o;
        do @(negedge link_clk_i); while (!(rx_valid_o === 1'b1 && rx_slot_o === SLOT_ZERO));
        b1 = rx_data_o;
        check((b0 ^ b1) === (FAS_BYTE ^ NFAS_BYTE) && (b0 === FAS_BYTE || b1 === FAS_BYTE), "sync pair");
        @(posedge clk_i);
        corrupt <= 1'b1;
        do begin
            @(negedge clk_i);
            n++;
        end while (align_lost_o !== 1'b1 && n < 6000);
        check(n >= 3000 && n <= 4700, "loss after three misses");
        repeat (8) @(negedge clk_i);
        check(aligned_o === 1'b0, "alignment dropped");
        @(posedge clk_i);
        corrupt <= 1'b0;
        n = 0;
        do begin
            @(negedge clk_i);
            n++;
        end while (aligned_o !== 1'b1 && n < 60000);
        check(aligned_o === 1'b1 && n > 3000, "realignment");
    endtask : t_align

    initial begin
        rstn_i <= 1'b0;
        repeat (2) @(posedge clk_i);
        rstn_i <= 1'b1;
        t_reset();
        t_frame0();
        t_payload();
        t_align();
        close_out();
    end
endmodule : testbench
